/* File: design/fsr_defs.svh */
// constants for the flash suspend/resume and read sequencer
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH
// Contract
// R1: suspend only when idle-flag clear, busy, suspendable
// R2: suspend ignored during whole-chip erase
// R3: erase-suspended: refuse status writes and erases
// R4: program-suspended: refuse status writes and programs
// R5: ignore program/erase to the suspended sector
// R6: suspend sets flag at once, busy clears later
// R7: host waits suspend latency after resume
// R8: power-up clears suspend flag
// R9: resume only when flagged and not busy
// R10: resume clears flag, busy within 200 ns
// R11: read code and 24-bit address sampled rising
// R12: data out MSB first on falling edges
// R13: address increments per byte until deselect
// R14: plain read ignored while busy
// R15: fast read eight dummy clocks, input ignored
// R16: four-wire dummy count 4/6/8/8, default 4
// R17: dual output read, two bits per clock
// R18: host releases second line before data
// R19: quad output read needs quad enable
// R20: dual I/O address two bits per clock
// R21: mode byte upper nibble used, lower ignored
// R22: mode bits 5:4 = 10 skip next code
// R23: host sends ones to leave continuous mode
// R24: code eight bits MSB first after select
`define FSR_CLK_MHZ 20
`define FSR_SUSP_LAT_NS 20000
`define FSR_SUSP_CYC ((`FSR_SUSP_LAT_NS * `FSR_CLK_MHZ) / 1000)
`define FSR_RESUME_NS 200
`define FSR_RESUME_CYC ((`FSR_RESUME_NS * `FSR_CLK_MHZ) / 1000)
`define FSR_CTRL_OFS 8'h00
`define FSR_STAT_OFS 8'h04
`define FSR_CTRL_RST 4'h0
`define FSR_RESP_OKAY 2'h0
`define FSR_RESP_SLVERR 2'h2
`define FSR_CMD_BITS 6'h08
`define FSR_ADDR_BITS 6'h18
`define FSR_MODE_BITS 6'h08
`define FSR_DUMMY_STD 4'h8
`define FSR_SEC_LSB 12
`define FSR_OP_READ 8'h03
`define FSR_OP_FREAD 8'h0B
`define FSR_OP_DOUT 8'h3B
`define FSR_OP_QOUT 8'h6B
`define FSR_OP_DIO 8'hBB
`define FSR_OP_SUSP 8'h75
`define FSR_OP_RESM 8'h7A
`define FSR_OP_SE 8'h20
`define FSR_OP_HBE 8'h52
`define FSR_OP_BE 8'hD8
`define FSR_OP_CE1 8'hC7
`define FSR_OP_CE2 8'h60
`define FSR_OP_SECE 8'h44
`define FSR_OP_PP 8'h02
`define FSR_OP_QPP 8'h32
`define FSR_OP_SECP 8'h42
`endif

/* File: design/fsr_flash_seq.sv */
// serial flash read, suspend and resume sequencer with axi4-lite status
`timescale 1ns/1ps
`include "fsr_defs.svh"
module fsr_flash_seq
  import fsr_pkg::*;
#(
  parameter int OP_CYCLES = 1000
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // serial link pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  // array read port
  output logic [23:0] o_mem_addr,
  input wire logic [7:0] i_mem_data,
  // status
  output logic o_busy,
  output logic o_suspend_flag,
  // axi4-lite write
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  // axi4-lite read
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready
);
  localparam int LAT_C = `FSR_SUSP_CYC;
  localparam int RES_C = `FSR_RESUME_CYC;

  // pin synchronisers
  logic cs_s1, cs_s2, cs_s3, sck_s1, sck_s2, sck_s3;
  logic [3:0] io_s1, io_s2;
  always_ff @(posedge i_core_clk) begin
    cs_s1 <= i_cs_n;
    cs_s2 <= cs_s1;
    cs_s3 <= cs_s2;
    sck_s1 <= i_sclk;
    sck_s2 <= sck_s1;
    sck_s3 <= sck_s2;
    io_s1 <= i_io;
    io_s2 <= io_s1;
  end

  // link events seen on the core clock
  logic rise, fall, cs_fall, cs_rise;
  assign rise = sck_s2 & ~sck_s3 & ~cs_s2;
  assign fall = ~sck_s2 & sck_s3 & ~cs_s2;
  assign cs_fall = ~cs_s2 & cs_s3;
  assign cs_rise = cs_s2 & ~cs_s3;

  // state declarations
  fsr_state_e st_reg, st_next;
  fsr_cfg_s cfg_reg, cfg_next;
  fsr_job_s act_reg, act_next, hold_reg, hold_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [23:0] sr_reg, sr_next, maddr_reg, maddr_next;
  logic [7:0] op_reg, op_next, dout_reg, dout_next;
  logic [3:0] dleft_reg, dleft_next, io_reg, io_next, oe_reg, oe_next;
  logic cont_reg, cont_next, busy_reg, busy_next, susp_reg, susp_next;
  logic ign_reg, ign_next;
  logic [8:0] lat_reg, lat_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic qen, fourw;
  logic [1:0] dsel;
  assign qen = ctrl_reg[0];
  assign fourw = ctrl_reg[1];
  assign dsel = ctrl_reg[3:2];

  // shift bits in from the lines in use
  function automatic logic [23:0] shin(input logic [23:0] s, input logic [2:0] w,
                                       input logic [3:0] io);
    case (w)
      3'h1: shin = {s[22:0], io[0]};
      3'h2: shin = {s[21:0], io[1:0]};
      default: shin = {s[19:0], io};
    endcase
  endfunction

  // top bits of a byte placed on the output lines
  function automatic logic [3:0] outbits(input logic [7:0] b, input logic [2:0] w);
    case (w)
      3'h1: outbits = {2'b00, b[7], 1'b0};
      3'h2: outbits = {2'b00, b[7:6]};
      default: outbits = b[7:4];
    endcase
  endfunction

  // serial command, address, dummy and data sequencing
  always_comb begin
    logic [7:0] byte_v;
    byte_v = dout_reg;
    st_next = st_reg;
    cnt_next = cnt_reg;
    sr_next = sr_reg;
    op_next = op_reg;
    cfg_next = cfg_reg;
    cont_next = cont_reg;
    dout_next = dout_reg;
    dleft_next = dleft_reg;
    maddr_next = maddr_reg;
    io_next = io_reg;
    oe_next = oe_reg;
    if (cs_s2) begin
      // R13 deselect ends the stream
      st_next = FSR_IDLE;
      oe_next = 4'h0;
    end else if (cs_fall) begin
      sr_next = 24'h000000;
      if (cont_reg) begin
        // R22 code byte skipped
        st_next = busy_reg ? FSR_IGN : FSR_ADDR;
        op_next = `FSR_OP_DIO;
        cfg_next = '{1'b1, 1'b1, 3'h2, 3'h2, 4'h0};
        cnt_next = `FSR_ADDR_BITS;
      end else begin
        // R24 code shifted first
        st_next = FSR_CMD;
        cnt_next = `FSR_CMD_BITS;
        cfg_next.in_w = fourw ? 3'h4 : 3'h1;
      end
    end else if (rise) begin
      // R11 sample on rising edge
      sr_next = shin(sr_reg, cfg_reg.in_w, io_s2);
      cnt_next = cnt_reg - {3'b000, cfg_reg.in_w};
      case (st_reg)
        FSR_CMD: begin
          if (cnt_next == 6'h00) begin
            op_next = sr_next[7:0];
            cfg_next = '{1'b0, 1'b0, fourw ? 3'h4 : 3'h1, fourw ? 3'h4 : 3'h1, 4'h0};
            cnt_next = `FSR_ADDR_BITS;
            st_next = FSR_IGN;
            case (sr_next[7:0])
              `FSR_OP_READ: begin
                // R14 refused while busy
                cfg_next.is_read = 1'b1;
                st_next = busy_reg ? FSR_IGN : FSR_ADDR;
              end
              `FSR_OP_FREAD: begin
                // R15 R16 dummy clock count
                cfg_next.is_read = 1'b1;
                cfg_next.dummy = `FSR_DUMMY_STD;
                if (fourw) begin
                  cfg_next.dummy = (dsel == 2'b00) ? 4'h4 : (dsel == 2'b01) ? 4'h6 : 4'h8;
                end
                st_next = busy_reg ? FSR_IGN : FSR_ADDR;
              end
              `FSR_OP_DOUT: begin
                // R17 dual output
                cfg_next = '{1'b1, 1'b0, 3'h1, 3'h2, `FSR_DUMMY_STD};
                st_next = busy_reg ? FSR_IGN : FSR_ADDR;
              end
              `FSR_OP_QOUT: begin
                // R19 needs quad enable
                cfg_next = '{1'b1, 1'b0, 3'h1, 3'h4, `FSR_DUMMY_STD};
                st_next = (busy_reg || !qen) ? FSR_IGN : FSR_ADDR;
              end
              `FSR_OP_DIO: begin
                // R20 two address bits per clock
                cfg_next = '{1'b1, 1'b1, 3'h2, 3'h2, 4'h0};
                st_next = busy_reg ? FSR_IGN : FSR_ADDR;
              end
              `FSR_OP_SE, `FSR_OP_HBE, `FSR_OP_BE, `FSR_OP_SECE,
              `FSR_OP_PP, `FSR_OP_QPP, `FSR_OP_SECP: st_next = FSR_ADDR;
              `FSR_OP_CE1, `FSR_OP_CE2, `FSR_OP_SUSP, `FSR_OP_RESM: st_next = FSR_WAIT;
              default: st_next = FSR_IGN;
            endcase
          end
        end
        FSR_ADDR: begin
          if (cnt_next == 6'h00) begin
            maddr_next = sr_next;
            dleft_next = 4'h0;
            if (cfg_reg.mode_en) begin
              st_next = FSR_MODE;
              cnt_next = `FSR_MODE_BITS;
            end else if (cfg_reg.dummy != 4'h0) begin
              st_next = FSR_DUMMY;
              cnt_next = {2'b00, cfg_reg.dummy};
            end else begin
              st_next = cfg_reg.is_read ? FSR_DATA : FSR_WAIT;
            end
          end
        end
        FSR_MODE: begin
          if (cnt_next == 6'h00) begin
            // R21 R22 only bits 5:4 kept
            cont_next = (sr_next[5:4] == 2'b10);
            st_next = FSR_DATA;
          end
        end
        FSR_DUMMY: begin
          // R15 input ignored here
          cnt_next = cnt_reg - 6'h01;
          if (cnt_reg == 6'h01) begin
            st_next = FSR_DATA;
          end
        end
        default: begin
          cnt_next = cnt_reg;
        end
      endcase
    end else if (fall && st_reg == FSR_DATA) begin
      // R12 R13 msb first, address steps per byte
      if (dleft_reg == 4'h0) begin
        byte_v = i_mem_data;
        maddr_next = maddr_reg + 24'h000001;
      end
      io_next = outbits(byte_v, cfg_reg.out_w);
      dout_next = byte_v << cfg_reg.out_w;
      dleft_next = ((dleft_reg == 4'h0) ? 4'h8 : dleft_reg) - {1'b0, cfg_reg.out_w};
      oe_next = (cfg_reg.out_w == 3'h1) ? 4'h2 : (cfg_reg.out_w == 3'h2) ? 4'h3 : 4'hF;
    end
  end

  // operation engine: dispatch at deselect
  logic disp, in_susp_sec, is_erase, is_prog, is_chip;
  assign disp = cs_rise && st_reg == FSR_WAIT;
  assign in_susp_sec = susp_reg && maddr_reg[23:`FSR_SEC_LSB] == hold_reg.sec;
  assign is_erase = op_reg == `FSR_OP_SE || op_reg == `FSR_OP_HBE ||
                    op_reg == `FSR_OP_BE || op_reg == `FSR_OP_SECE;
  assign is_prog = op_reg == `FSR_OP_PP || op_reg == `FSR_OP_QPP || op_reg == `FSR_OP_SECP;
  assign is_chip = op_reg == `FSR_OP_CE1 || op_reg == `FSR_OP_CE2;

  // busy timing, suspend and resume
  always_comb begin
    busy_next = busy_reg;
    susp_next = susp_reg;
    act_next = act_reg;
    hold_next = hold_reg;
    lat_next = lat_reg;
    ign_next = ign_reg;
    if (lat_reg != 9'h000) begin
      // R6 busy drops within the suspend latency
      lat_next = lat_reg - 9'h001;
      if (lat_reg == 9'h001) begin
        busy_next = 1'b0;
        act_next.kind = FSR_K_NONE;
      end
    end else if (busy_reg) begin
      act_next.cnt = act_reg.cnt - 24'h000001;
      if (act_reg.cnt <= 24'h000001) begin
        busy_next = 1'b0;
        act_next.kind = FSR_K_NONE;
      end
    end
    if (disp) begin
      ign_next = 1'b1;
      if (op_reg == `FSR_OP_SUSP) begin
        // R1 R2 R6 suspend acceptance
        if (!susp_reg && busy_reg && lat_reg == 9'h000 &&
            (act_reg.kind == FSR_K_ERASE || act_reg.kind == FSR_K_PROG)) begin
          susp_next = 1'b1;
          busy_next = 1'b1;
          lat_next = 9'(LAT_C);
          hold_next = act_reg;
          ign_next = 1'b0;
        end
      end else if (op_reg == `FSR_OP_RESM) begin
        // R9 R10 resume acceptance
        if (susp_reg && !busy_reg) begin
          susp_next = 1'b0;
          busy_next = 1'b1;
          act_next = hold_reg;
          ign_next = 1'b0;
        end
      end else if (!busy_reg) begin
        // R3 R4 R5 refusals while suspended
        if ((is_erase && !(susp_reg && (hold_reg.kind == FSR_K_ERASE || in_susp_sec))) ||
            (is_prog && !(susp_reg && (hold_reg.kind == FSR_K_PROG || in_susp_sec))) ||
            (is_chip && !susp_reg)) begin
          busy_next = 1'b1;
          act_next.cnt = 24'(OP_CYCLES);
          act_next.sec = maddr_reg[23:`FSR_SEC_LSB];
          act_next.kind = FSR_K_FIXED;
          if (op_reg != `FSR_OP_SECE && is_erase) begin
            act_next.kind = FSR_K_ERASE;
          end
          if (op_reg != `FSR_OP_SECP && is_prog) begin
            act_next.kind = FSR_K_PROG;
          end
          ign_next = 1'b0;
        end
      end
    end
  end

  // axi4-lite slave state
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next, rdata_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awrdy_next, wrdy_next, bvalid_next, arrdy_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;

  // write and read channel handling
  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    ctrl_next = ctrl_reg;
    bvalid_next = o_axi_bvalid;
    bresp_next = o_axi_bresp;
    rvalid_next = o_axi_rvalid;
    rdata_next = o_axi_rdata;
    rresp_next = o_axi_rresp;
    if (o_axi_bvalid && i_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (i_axi_awvalid && o_axi_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      w_have_next = 1'b1;
      w_data_next = i_axi_wdata;
      w_strb_next = i_axi_wstrb;
    end
    if (aw_have_next && w_have_next && !bvalid_next) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `FSR_RESP_OKAY;
      if (aw_addr_next == `FSR_CTRL_OFS) begin
        if (w_strb_next[0]) begin
          ctrl_next = w_data_next[3:0];
        end
      end else if (aw_addr_next != `FSR_STAT_OFS) begin
        bresp_next = `FSR_RESP_SLVERR;
      end
    end
    if (o_axi_rvalid && i_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (i_axi_arvalid && o_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = `FSR_RESP_OKAY;
      rdata_next = 32'h00000000;
      if (i_axi_araddr == `FSR_CTRL_OFS) begin
        rdata_next = {28'h0000000, ctrl_reg};
      end else if (i_axi_araddr == `FSR_STAT_OFS) begin
        rdata_next = {28'h0000000, ign_reg, cont_reg, susp_reg, busy_reg};
      end else begin
        rresp_next = `FSR_RESP_SLVERR;
      end
    end
    awrdy_next = !aw_have_next && !bvalid_next;
    wrdy_next = !w_have_next && !bvalid_next;
    arrdy_next = !rvalid_next;
  end

  // register stage
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_reg <= FSR_IDLE;
      cfg_reg <= '0;
      cnt_reg <= 6'h00;
      sr_reg <= 24'h000000;
      op_reg <= 8'h00;
      cont_reg <= 1'b0;
      dout_reg <= 8'h00;
      dleft_reg <= 4'h0;
      maddr_reg <= 24'h000000;
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
      busy_reg <= 1'b0;
      // R8 suspension cleared at power-up
      susp_reg <= 1'b0;
      act_reg <= '0;
      hold_reg <= '0;
      lat_reg <= 9'h000;
      ign_reg <= 1'b0;
      // R16 default dummy select gives four
      ctrl_reg <= `FSR_CTRL_RST;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      o_axi_awready <= 1'b0;
      o_axi_wready <= 1'b0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= 2'h0;
      o_axi_arready <= 1'b0;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h00000000;
      o_axi_rresp <= 2'h0;
    end else begin
      st_reg <= st_next;
      cfg_reg <= cfg_next;
      cnt_reg <= cnt_next;
      sr_reg <= sr_next;
      op_reg <= op_next;
      cont_reg <= cont_next;
      dout_reg <= dout_next;
      dleft_reg <= dleft_next;
      maddr_reg <= maddr_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
      susp_reg <= susp_next;
      act_reg <= act_next;
      hold_reg <= hold_next;
      lat_reg <= lat_next;
      ign_reg <= ign_next;
      ctrl_reg <= ctrl_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      o_axi_awready <= awrdy_next;
      o_axi_wready <= wrdy_next;
      o_axi_bvalid <= bvalid_next;
      o_axi_bresp <= bresp_next;
      o_axi_arready <= arrdy_next;
      o_axi_rvalid <= rvalid_next;
      o_axi_rdata <= rdata_next;
      o_axi_rresp <= rresp_next;
    end
  end

  // outputs straight from flops
  assign o_io = io_reg;
  assign o_io_oe = oe_reg;
  assign o_mem_addr = maddr_reg;
  assign o_busy = busy_reg;
  assign o_suspend_flag = susp_reg;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  // suspend acceptance and latency, refusals, resume and read output
  chk_susp_accept: assert property (disp && op_reg == `FSR_OP_SUSP && !susp_reg && busy_reg &&
    lat_reg == 9'h000 && act_reg.kind == FSR_K_ERASE |=> susp_reg) // R1
    else $error("suspend not accepted");
  chk_chip_nosusp: assert property (disp && op_reg == `FSR_OP_SUSP &&
    act_reg.kind == FSR_K_FIXED |=> susp_reg == $past(susp_reg)) // R2
    else $error("suspend taken during fixed erase");
  chk_erase_lock: assert property (disp && is_erase && susp_reg &&
    hold_reg.kind == FSR_K_ERASE |=> !$rose(busy_reg)) // R3
    else $error("erase started while erase suspended");
  chk_prog_lock: assert property (disp && is_prog && susp_reg &&
    hold_reg.kind == FSR_K_PROG |=> !$rose(busy_reg)) // R4
    else $error("program started while program suspended");
  chk_same_sector: assert property (disp && (is_prog || is_erase) && in_susp_sec
    |=> !$rose(busy_reg)) // R5
    else $error("operation started on suspended sector");
  chk_susp_latency: assert property ($rose(susp_reg) |-> ##[1:LAT_C] !busy_reg) // R6
    else $error("busy held past suspend latency");
  chk_resume_busy: assert property ($fell(susp_reg) |-> ##[0:RES_C] busy_reg) // R10
    else $error("busy not raised after resume");
  chk_read_idle: assert property ((|oe_reg) |-> !busy_reg) // R14
    else $error("data driven while busy");
  chk_msb_first: assert property (st_reg == FSR_DATA && fall && dleft_reg == 4'h0 &&
    cfg_reg.out_w == 3'h1 |=> io_reg[1] == $past(i_mem_data[7]) &&
    maddr_reg == $past(maddr_reg) + 24'h000001) // R12
    else $error("byte not started msb first");
endmodule

/* File: design/fsr_pkg.sv */
// types for the flash suspend/resume and read sequencer
package fsr_pkg;
  typedef enum logic [2:0] {
    FSR_IDLE = 3'b000,
    FSR_CMD = 3'b001,
    FSR_ADDR = 3'b011,
    FSR_MODE = 3'b010,
    FSR_DUMMY = 3'b110,
    FSR_DATA = 3'b111,
    FSR_WAIT = 3'b101,
    FSR_IGN = 3'b100
  } fsr_state_e;
  typedef enum logic [1:0] {
    FSR_K_NONE = 2'b00,
    FSR_K_ERASE = 2'b01,
    FSR_K_FIXED = 2'b10,
    FSR_K_PROG = 2'b11
  } fsr_kind_e;
  typedef struct packed {
    logic is_read;
    logic mode_en;
    logic [2:0] in_w;
    logic [2:0] out_w;
    logic [3:0] dummy;
  } fsr_cfg_s;
  typedef struct packed {
    fsr_kind_e kind;
    logic [11:0] sec;
    logic [23:0] cnt;
  } fsr_job_s;
endpackage

/* File: test/fsr_flash_seq_test.sv */
// self-checking bench for the flash suspend, resume and read sequencer
`timescale 1ns/1ps
`include "fsr_defs.svh"
module fsr_flash_seq_test;
  import fsr_pkg::*;
  localparam int OPC = 3000;
  logic clk, rst_b, cs_n, sclk, busy, sflag;
  logic flip = 1'b0;
  logic awv, wv, bready, arv, rready, aw_rdy, w_rdy, bvalid, ar_rdy, rvalid;
  logic [7:0] awaddr, araddr, mem, b;
  logic [31:0] wdata, rdata, r;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] h_io, h_oe, d_io, d_oe, w_io;
  logic [23:0] m_addr, a;
  int n_errors, samples_checked;
  function automatic logic [7:0] mem_f(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'hA5;
  endfunction
  // array contents and the resolved link wire
  assign mem = mem_f(m_addr);
  assign w_io = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & {4{flip}});
  fsr_flash_seq #(.OP_CYCLES(OPC)) i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_io(w_io), .o_io(d_io), .o_io_oe(d_oe), .o_mem_addr(m_addr),
    .i_mem_data(mem), .o_busy(busy), .o_suspend_flag(sflag), .i_axi_awaddr(awaddr),
    .i_axi_awvalid(awv), .o_axi_awready(aw_rdy), .i_axi_wdata(wdata), .i_axi_wstrb(4'hF),
    .i_axi_wvalid(wv), .o_axi_wready(w_rdy), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid),
    .i_axi_bready(bready), .i_axi_araddr(araddr), .i_axi_arvalid(arv),
    .o_axi_arready(ar_rdy), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
    .o_axi_rvalid(rvalid), .i_axi_rready(rready));
  fsr_host_model i_host (.i_core_clk(clk), .i_io(w_io), .i_dev_oe(d_oe), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_io(h_io), .o_io_oe(h_oe));
  // clock and released-line pattern
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) flip <= ~flip;
  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] o);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy) awv <= 1'b0;
      if (w_rdy) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    o = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] o);
    @(posedge clk);
    araddr <= ad;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_rdy) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    o = rresp;
    rready <= 1'b0;
  endtask
  task automatic stat(input int i, input logic e);
    rd(8'h04, r, rs);
    chk(r[i], e);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] ad, input int n);
    i_host.open_frame();
    i_host.send({op, 24'h0}, 8, 1);
    if (n > 0) i_host.send(ad, n, 1);
    i_host.close_frame();
  endtask
  // read frame of three bytes, or a refused one that must stay silent
  task automatic rdf(input logic [7:0] op, input logic [23:0] ad, input int dm, input int w,
    input logic ign);
    logic [7:0] bt;
    i_host.open_frame();
    i_host.send({op, 24'h0}, 8, 1);
    i_host.send({ad, 8'h00}, 24, 1);
    i_host.dummy(dm);
    for (int k = 0; k < 3; k++) begin
      i_host.recv(w, bt);
      if (!ign) chk(bt, mem_f(ad + 24'(k)));
    end
    if (ign) chk(i_host.seen_oe, 4'h0);
    i_host.close_frame();
  endtask
  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    test_done();
  end
  // main sequence
  initial begin
    {rst_b, awv, wv, bready, arv, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    void'($urandom(93));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk(busy, 1'b0);
    chk(sflag, 1'b0);
    rd(8'h00, r, rs);
    chk(r, 32'h0);
    rd(8'h40, r, rs);
    chk(rs, `FSR_RESP_SLVERR);
    wr(8'h40, 32'h1, rs);
    chk(rs, `FSR_RESP_SLVERR);
    rdf(8'h03, 24'hFFFFFE, 0, 1, 1'b0);
    rdf(8'h0B, 24'($urandom), 8, 1, 1'b0);
    rdf(8'h3B, 24'($urandom), 8, 2, 1'b0);
    rdf(8'h6B, 24'($urandom), 8, 4, 1'b1);
    wr(8'h00, 32'h1, rs);
    rdf(8'h6B, 24'($urandom), 8, 4, 1'b0);
    // four-wire fast read, dummy count from each select value
    for (int d = 0; d < 4; d++) begin
      wr(8'h00, 32'(3 + 4 * d), rs);
      a = 24'($urandom);
      i_host.open_frame();
      i_host.send({8'h0B, 24'h0}, 8, 4);
      i_host.send({a, 8'h00}, 24, 4);
      i_host.dummy(d == 0 ? 4 : (d == 1 ? 6 : 8));
      i_host.recv(4, b);
      chk(b, mem_f(a));
      i_host.close_frame();
    end
    wr(8'h00, 32'h1, rs);
    // dual address lines with mode bits, then an address-only frame
    a = 24'($urandom);
    i_host.open_frame();
    i_host.send({8'hBB, 24'h0}, 8, 1);
    i_host.send({a, 8'h2F}, 32, 2);
    i_host.recv(2, b);
    chk(b, mem_f(a));
    i_host.close_frame();
    stat(2, 1'b1);
    a = a ^ 24'h00F0F0;
    i_host.open_frame();
    i_host.send({a, 8'hFF}, 32, 2);
    i_host.recv(2, b);
    chk(b, mem_f(a));
    i_host.close_frame();
    stat(2, 1'b0);
    // erase, refused read, suspend, refused commands, resume
    a = 24'($urandom);
    cmd(8'h20, {a, 8'h00}, 24);
    chk(busy, 1'b1);
    rdf(8'h03, a, 0, 1, 1'b1);
    cmd(8'h75, 32'h0, 0);
    chk(sflag, 1'b1);
    repeat (`FSR_SUSP_CYC) @(posedge clk);
    chk(busy, 1'b0);
    cmd(8'hD8, {a ^ 24'h010000, 8'h00}, 24);
    stat(3, 1'b1);
    cmd(8'h02, {a, 8'h5A}, 32);
    stat(3, 1'b1);
    cmd(8'h75, 32'h0, 0);
    stat(3, 1'b1);
    rdf(8'h03, a, 0, 1, 1'b0);
    cmd(8'h7A, 32'h0, 0);
    chk(sflag, 1'b0);
    chk(busy, 1'b1);
    cmd(8'h7A, 32'h0, 0);
    stat(3, 1'b1);
    // long wait before the next suspend
    repeat (OPC) @(posedge clk);
    chk(busy, 1'b0);
    // program suspend refuses other programs
    cmd(8'h02, {a, 8'h5A}, 32);
    cmd(8'h75, 32'h0, 0);
    chk(sflag, 1'b1);
    repeat (`FSR_SUSP_CYC) @(posedge clk);
    cmd(8'h32, {a ^ 24'h100000, 8'h00}, 32);
    stat(3, 1'b1);
    cmd(8'h7A, 32'h0, 0);
    repeat (OPC) @(posedge clk);
    // whole-chip erase never suspends
    cmd(8'hC7, 32'h0, 0);
    cmd(8'h75, 32'h0, 0);
    chk(sflag, 1'b0);
    stat(3, 1'b1);
    repeat (OPC) @(posedge clk);
    chk(busy, 1'b0);
    test_done();
  end
endmodule

/* File: test/fsr_host_model.sv */
// host-side serial controller model that drives the flash link
`timescale 1ns/1ps
module fsr_host_model (
  // clock
  input wire logic i_core_clk,
  // link lines as seen on the wire
  input wire logic [3:0] i_io,
  input wire logic [3:0] i_dev_oe,
  // link lines driven by the host
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe
);
  logic [3:0] seen_oe;
  // idle link: deselected, clock parked low
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
    o_io_oe = 4'h0;
  end
  // remembers whether the device drove any line inside a frame
  always @(posedge i_core_clk) begin
    if (o_cs_n) seen_oe <= 4'h0;
    else seen_oe <= seen_oe | i_dev_oe;
  end
  // one link clock: lines change on the fall, sampled just before the rise
  task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] got);
    o_io <= v;
    o_io_oe <= oe;
    repeat (4) @(posedge i_core_clk);
    got = i_io;
    o_sclk <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_sclk <= 1'b0;
  endtask
  task automatic open_frame;
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask
  // clock stands still low outside frames
  task automatic close_frame;
    repeat (4) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    o_io_oe <= 4'h0;
    repeat (12) @(posedge i_core_clk);
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] g;
    for (int i = 0; i < n; i += w) begin
      tick(v[31:28] >> (4 - w), 4'((1 << w) - 1), g);
      v = v << w;
    end
  endtask
  task automatic dummy(input int n);
    logic [3:0] g;
    repeat (n) tick(4'($urandom), 4'h1, g);
  endtask
  task automatic recv(input int w, output logic [7:0] b);
    logic [3:0] g;
    b = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      tick(4'h0, 4'h0, g);
      b = (b << w) | 8'(w == 1 ? {3'b000, g[1]} : g & 4'((1 << w) - 1));
    end
  endtask
endmodule
